// ==== verilog/exb_defines.vh ====
// Constants for the external bus expansion block
`ifndef EXB_DEFINES_VH
`define EXB_DEFINES_VH

// Register byte offsets
`define EXB_OFF_MODE    8'h00
`define EXB_OFF_FETCH   8'h04
`define EXB_OFF_WAIT    8'h08
`define EXB_OFF_PDATA   8'h0c
`define EXB_OFF_PDIR    8'h10
`define EXB_OFF_PIN     8'h14
`define EXB_OFF_ACCADR  8'h18
`define EXB_OFF_ACCDAT  8'h1c
`define EXB_OFF_ACCCMD  8'h20
`define EXB_OFF_STATUS  8'h24

// Mode register fields
`define EXB_MM_MSB      2
`define EXB_MM_LSB      0
`define EXB_EXT_BIT     7

// Expansion mode codes and port-5 address pin counts
`define EXB_MM_PORT     3'h0
`define EXB_MM_256      3'h1
`define EXB_MM_4K       3'h2
`define EXB_MM_16K      3'h3
`define EXB_P5W_256     4'h0
`define EXB_P5W_4K      4'h4
`define EXB_P5W_16K     4'h6
`define EXB_P5W_48K     4'h8

// Address map and fetch control
`define EXB_EXT_BASE    16'h4000
`define EXB_FETCH_PLAIN 8'h00

// Port data layout: port4 [7:0], port5 [15:8], port9 [19:16]
`define EXB_P4_MSB      7
`define EXB_P4_LSB      0
`define EXB_P5_MSB      15
`define EXB_P5_LSB      8
`define EXB_P9_MSB      19
`define EXB_P9_LSB      16

// Command and status bits
`define EXB_CMD_GO      0
`define EXB_CMD_WR      1
`define EXB_ST_BUSY     0
`define EXB_ST_ERR      1
`define EXB_ST_DONE     2
`define EXB_ST_TAG      3
`define EXB_ST_EXP      4
`define EXB_ST_RD_LSB   8
`define EXB_ST_RD_MSB   15

// Reset values
`define EXB_RST_BYTE    8'h00
`define EXB_RST_WORD    32'h0000_0000
`define EXB_RST_WAIT    4'h0
`define EXB_RST_PORT    20'h0_0000
`define EXB_RST_ADDR    16'h0000

`endif

// ==== verilog/exb_port5_mux.v ====
// Per-pin split of port 5 between upper address lines and general port bits
`timescale 1ns/1ps
`default_nettype none

module exb_port5_mux (
	// Selection
	input  wire [3:0] addrWidth,
	// Sources
	input  wire [7:0] upperAddr,
	input  wire [7:0] portOut,
	input  wire [7:0] portDir,
	// Pin values
	output wire [7:0] pinOut,
	output wire [7:0] pinOe_n
);

	////////////////////////////////////////////////////////////////////////
	// Low pins carry address first, so a wider space only adds pins on top
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : gPin
			localparam [3:0] IDX = i;
			wire isAddr;
			assign isAddr     = (IDX < addrWidth);                        // R2
			assign pinOut[i]  = isAddr ? upperAddr[i] : portOut[i];       // R3
			assign pinOe_n[i] = isAddr ? 1'b0 : ~portDir[i];              // R3
		end
	endgenerate

endmodule // exb_port5_mux

`default_nettype wire

// ==== verilog/exb_bus_cycle.v ====
// Sequencer for one external read or write on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
`include "exb_defines.vh"

module exb_bus_cycle (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        reset_n,
	// Request
	input  wire        start,
	input  wire        writeSel,
	input  wire [15:0] addr,
	input  wire [7:0]  wdata,
	input  wire [3:0]  waitCount,
	// Bus pins, before the pin registers
	input  wire [7:0]  adIn,
	output reg  [7:0]  adOut,
	output reg         adDrive,
	output wire [7:0]  upperAddr,
	output reg         addrStrobe,
	output reg         readStrobe_n,
	output reg         writeStrobe_n,
	// Result
	output reg  [7:0]  rdata,
	output wire        busy,
	output reg         done
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_HOLD = 3'h2;
	localparam [2:0] ST_DATA = 3'h3;
	localparam [2:0] ST_END  = 3'h4;

	reg [2:0]  state_reg;
	reg [3:0]  waitLeft_reg;
	reg        isWrite_reg;
	reg [15:0] addr_reg;
	reg [7:0]  wdata_reg;

	assign busy      = (state_reg != ST_IDLE);
	assign upperAddr = addr_reg[15:8];

	////////////////////////////////////////////////////////////////////////
	// State and request capture
	always @(posedge clk_sys) begin
		done <= 1'b0;
		if (!reset_n) begin
			state_reg    <= ST_IDLE;
			waitLeft_reg <= `EXB_RST_WAIT;
			isWrite_reg  <= 1'b0;
			addr_reg     <= `EXB_RST_ADDR;
			wdata_reg    <= `EXB_RST_BYTE;
			rdata        <= `EXB_RST_BYTE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						addr_reg    <= addr;
						wdata_reg   <= wdata;
						isWrite_reg <= writeSel;
						state_reg   <= ST_ADDR;
					end
				end
				ST_ADDR: state_reg <= ST_HOLD;
				ST_HOLD: begin
					waitLeft_reg <= waitCount;
					state_reg    <= ST_DATA;
				end
				ST_DATA: begin
					// Wait cycles stretch the strobe for slow parts
					if (waitLeft_reg == `EXB_RST_WAIT) begin
						state_reg <= ST_END;
					end else begin
						waitLeft_reg <= waitLeft_reg - 4'h1;
					end
				end
				ST_END: begin
					// Pins lag a cycle: this is the last cycle the read strobe is low
					if (!isWrite_reg)
						rdata <= adIn;                              // R10
					done      <= 1'b1;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin values per state; address held one cycle past the strobe edge
	always @* begin
		adOut         = addr_reg[7:0];
		adDrive       = 1'b0;
		addrStrobe    = 1'b0;
		readStrobe_n  = 1'b1;
		writeStrobe_n = 1'b1;
		case (state_reg)
			ST_ADDR: begin
				adDrive    = 1'b1;                                  // R10
				addrStrobe = 1'b1;                                  // R10
			end
			ST_HOLD: adDrive = 1'b1;
			ST_DATA: begin
				adOut         = wdata_reg;
				adDrive       = isWrite_reg;
				readStrobe_n  = isWrite_reg;                        // R10
				writeStrobe_n = ~isWrite_reg;                       // R10
			end
			ST_END: begin
				adOut   = wdata_reg;
				adDrive = isWrite_reg;
			end
			default: adDrive = 1'b0;
		endcase
	end

endmodule // exb_bus_cycle

`default_nettype wire

// ==== verilog/exb_top.v ====
// External bus expansion: pin function select, bus sequencing, APB registers
// Contract
// R1 - External accesses only reach addresses 4000H to FFFFH outside internal memory.
// R2 - Port 5 carries none, four, six or eight upper address bits.
// R3 - Port 5 pins not used for address remain general port bits.
// R4 - Expansion with access pin high: port 4 is address/data, port 9 read/write.
// R5 - Extended bit 0 and fetch control 00H: plain mode, port9 bits 2-3 general.
// R6 - Extended bit 1 and fetch control nonzero: port9 bits 2-3 tag strobe and mode.
// R7 - While reset is low every bus and port pin is high impedance; the address latch strobe has no enable and is driven low.
// R8 - Reset low initialises all state; operation resumes when reset goes high.
// R9 - Software should program wait count and fetch control after reset.
// R10 - Each access drives low address, pulses address strobe, then read/write strobe.
`timescale 1ns/1ps
`default_nettype none
`include "exb_defines.vh"

module exb_top (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        reset_n,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Mode strap
	input  wire        externalAccessSelect,
	// Port 4: low address/data lines
	input  wire [7:0]  port4In,
	output reg  [7:0]  port4Out,
	output reg  [7:0]  port4Oe_n,
	// Port 5: upper address lines or general port
	input  wire [7:0]  port5In,
	output reg  [7:0]  port5Out,
	output reg  [7:0]  port5Oe_n,
	// Port 9: strobes or general port
	input  wire [3:0]  port9In,
	output reg  [3:0]  port9Out,
	output reg  [3:0]  port9Oe_n,
	// Address latch strobe
	output reg         addressLatchStrobe
);

	reg [7:0]  mode_reg;
	reg [7:0]  fetch_reg;
	reg [3:0]  wait_reg;
	reg [19:0] portData_reg;
	reg [19:0] portDir_reg;
	reg [15:0] accAddr_reg;
	reg [7:0]  accData_reg;
	reg        addrErr_reg;
	reg        done_reg;
	reg        start_reg;
	reg        startWr_reg;

	wire [2:0] expansionModeBits;
	wire       extendedModeBit;
	wire       expansionActive;
	wire       tagMode;
	wire       apbAccess;
	wire       apbWrite;
	wire       apbRead;
	wire       cmdWrite;
	wire       addrOk;
	wire       busBusy;
	wire       busDone;
	wire [7:0] busRdata;
	wire [7:0] adOut;
	wire       adDrive;
	wire [7:0] upperAddr;
	wire       addrStrobe;
	wire       readStrobe_n;
	wire       writeStrobe_n;
	wire [7:0] p5Out;
	wire [7:0] p5Oe_n;
	reg  [3:0] p5Width;
	reg        mapped;
	reg [31:0] readMux;
	wire       goTaken;
	wire       goRefused;
	wire       clrErr;
	wire       clrDone;

	////////////////////////////////////////////////////////////////////////
	// Pin function decode
	assign expansionModeBits = mode_reg[`EXB_MM_MSB:`EXB_MM_LSB];
	assign extendedModeBit   = mode_reg[`EXB_EXT_BIT];
	assign expansionActive   = externalAccessSelect &&
	                           (expansionModeBits != `EXB_MM_PORT);   // R4
	// Mixed settings fall back to plain connection so strobes stay sane
	assign tagMode = expansionActive && extendedModeBit &&
	                 (fetch_reg != `EXB_FETCH_PLAIN);                 // R6

	// Address width follows the expansion mode code
	// Port mode code keeps every port5 pin a general port bit
	always @* begin
		case (expansionModeBits)
			`EXB_MM_PORT: p5Width = `EXB_P5W_256;
			`EXB_MM_256:  p5Width = `EXB_P5W_256;                 // R2
			`EXB_MM_4K:   p5Width = `EXB_P5W_4K;                  // R2
			`EXB_MM_16K:  p5Width = `EXB_P5W_16K;                 // R2
			default:      p5Width = `EXB_P5W_48K;                 // R2
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// APB handshake: one wait state so every answer comes from a flop
	assign apbAccess = psel && penable && pready;
	assign apbWrite  = apbAccess && pwrite;
	assign apbRead   = apbAccess && !pwrite;
	assign cmdWrite  = apbWrite && (paddr == `EXB_OFF_ACCCMD) &&
	                   pwdata[`EXB_CMD_GO];
	// Only the space above internal memory may be reached externally
	assign addrOk    = expansionActive && (accAddr_reg >= `EXB_EXT_BASE); // R1
	// Go is dropped silently while a cycle runs; software polls busy first
	assign goTaken   = cmdWrite && !busBusy && !start_reg && addrOk;
	assign goRefused = cmdWrite && !busBusy && !start_reg && !addrOk;
	// Write-one-to-clear of the sticky status bits
	assign clrErr    = apbWrite && (paddr == `EXB_OFF_STATUS) && pwdata[`EXB_ST_ERR];
	assign clrDone   = apbWrite && (paddr == `EXB_OFF_STATUS) && pwdata[`EXB_ST_DONE];

	// Read mux and decode; unmapped offsets raise pslverr and read zero
	always @* begin
		mapped  = 1'b1;
		readMux = `EXB_RST_WORD;
		case (paddr)
			`EXB_OFF_MODE:   readMux[7:0]  = mode_reg;
			`EXB_OFF_FETCH:  readMux[7:0]  = fetch_reg;
			`EXB_OFF_WAIT:   readMux[3:0]  = wait_reg;
			`EXB_OFF_PDATA:  readMux[19:0] = portData_reg;
			`EXB_OFF_PDIR:   readMux[19:0] = portDir_reg;
			`EXB_OFF_PIN:    readMux[19:0] = {port9In, port5In, port4In};
			`EXB_OFF_ACCADR: readMux[15:0] = accAddr_reg;
			`EXB_OFF_ACCDAT: readMux[7:0]  = accData_reg;
			`EXB_OFF_ACCCMD: readMux       = `EXB_RST_WORD;
			`EXB_OFF_STATUS: begin
				readMux[`EXB_ST_BUSY] = busBusy || start_reg;
				readMux[`EXB_ST_ERR]  = addrErr_reg;
				readMux[`EXB_ST_DONE] = done_reg;
				readMux[`EXB_ST_TAG]  = tagMode;
				readMux[`EXB_ST_EXP]  = expansionActive;
				readMux[`EXB_ST_RD_MSB:`EXB_ST_RD_LSB] = busRdata;
			end
			default: mapped = 1'b0;
		endcase
	end

	// Answer registers
	// Ready rises in the second access cycle and drops at once; a master
	// that keeps penable high gets a repeated answer every second cycle
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `EXB_RST_WORD;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			prdata  <= (psel && penable && !pready && !pwrite) ?
			           readMux : `EXB_RST_WORD;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register map, one aligned word each, unused bits read zero:
	//   00 mode: [2:0] expansion code, [7] extended bit
	//   04 fetch control, nonzero with the extended bit selects tag mode
	//   08 wait: extra data strobe cycles per access
	//   0c port data, 10 port direction (1 drives)
	//      port4 in [7:0], port5 in [15:8], port9 in [19:16]
	//   14 pin levels, read only, same layout
	//   18 access address, 1c access write data
	//   20 command: bit0 go, bit1 write; reads zero
	//   24 status: busy, error, done, tag, expansion, last read byte
	// Error and done are sticky and clear by writing one to them
	// Software registers; reset clears them all
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			mode_reg     <= `EXB_RST_BYTE;                           // R8
			fetch_reg    <= `EXB_RST_BYTE;                           // R8
			wait_reg     <= `EXB_RST_WAIT;                           // R8
			portData_reg <= `EXB_RST_PORT;
			portDir_reg  <= `EXB_RST_PORT;
			accAddr_reg  <= `EXB_RST_ADDR;
			accData_reg  <= `EXB_RST_BYTE;
		end else if (apbWrite) begin
			case (paddr)
				`EXB_OFF_MODE:   mode_reg     <= pwdata[7:0];
				`EXB_OFF_FETCH:  fetch_reg    <= pwdata[7:0];
				`EXB_OFF_WAIT:   wait_reg     <= pwdata[3:0];
				`EXB_OFF_PDATA:  portData_reg <= pwdata[19:0];
				`EXB_OFF_PDIR:   portDir_reg  <= pwdata[19:0];
				`EXB_OFF_ACCADR: accAddr_reg  <= pwdata[15:0];
				`EXB_OFF_ACCDAT: accData_reg  <= pwdata[7:0];
				default:         accData_reg  <= accData_reg;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Access launch and sticky flags; a new event wins over a clear
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			start_reg   <= 1'b0;
			startWr_reg <= 1'b0;
			addrErr_reg <= 1'b0;
			done_reg    <= 1'b0;
		end else begin
			start_reg   <= goTaken;                                  // R1
			// Direction is sampled every cycle but only used at launch
			startWr_reg <= pwdata[`EXB_CMD_WR];
			if (goRefused)
				addrErr_reg <= 1'b1;                                // R1
			else if (clrErr)
				addrErr_reg <= 1'b0;
			if (busDone)
				done_reg <= 1'b1;
			else if (clrDone || cmdWrite)
				done_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus sequencer and port 5 split
	exb_bus_cycle uBus (
		.clk_sys       (clk_sys),
		.reset_n       (reset_n),
		.start         (start_reg),
		.writeSel      (startWr_reg),
		.addr          (accAddr_reg),
		.wdata         (accData_reg),
		.waitCount     (wait_reg),
		.adIn          (port4In),
		.adOut         (adOut),
		.adDrive       (adDrive),
		.upperAddr     (upperAddr),
		.addrStrobe    (addrStrobe),
		.readStrobe_n  (readStrobe_n),
		.writeStrobe_n (writeStrobe_n),
		.rdata         (busRdata),
		.busy          (busBusy),
		.done          (busDone)
	);

	// Outside expansion every port5 pin is a general port bit
	exb_port5_mux uPort5 (
		.addrWidth (expansionActive ? p5Width : `EXB_P5W_256),   // R2
		.upperAddr (upperAddr),
		.portOut   (portData_reg[`EXB_P5_MSB:`EXB_P5_LSB]),
		.portDir   (portDir_reg[`EXB_P5_MSB:`EXB_P5_LSB]),
		.pinOut    (p5Out),
		.pinOe_n   (p5Oe_n)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin functions by mode:
	//   port mode: all three ports follow the data and direction registers
	//   plain expansion: port4 address/data, port9 bits 0-1 read/write strobes
	//   tag expansion: as plain, plus port9 bits 2-3 tag strobe and tag mode
	//   port5 low pins carry upper address as wide as the code asks
	// Registering every pin costs a cycle of latency but keeps the pins
	// glitch free while the decode and the sequencer settle
	// Pin registers; every port pin floats while reset is held low, the latch strobe is driven low
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			port4Out           <= `EXB_RST_BYTE;
			port4Oe_n          <= ~`EXB_RST_BYTE;                    // R7
			port5Out           <= `EXB_RST_BYTE;
			port5Oe_n          <= ~`EXB_RST_BYTE;                    // R7
			port9Out           <= `EXB_RST_WAIT;
			port9Oe_n          <= ~`EXB_RST_WAIT;                    // R7
			addressLatchStrobe <= 1'b0;
		end else begin
			addressLatchStrobe <= expansionActive && addrStrobe;    // R10
			port5Out           <= p5Out;
			port5Oe_n          <= p5Oe_n;
			// Port 9 bits 0-1 are strobes in any expansion mode
			if (expansionActive) begin
				port4Out  <= adOut;                                 // R4
				port4Oe_n <= {8{~adDrive}};                         // R4
				port9Out[1:0]  <= {writeStrobe_n, readStrobe_n};    // R4
				port9Oe_n[1:0] <= 2'b00;                            // R4
			end else begin
				port4Out       <= portData_reg[`EXB_P4_MSB:`EXB_P4_LSB];
				port4Oe_n      <= ~portDir_reg[`EXB_P4_MSB:`EXB_P4_LSB];
				port9Out[1:0]  <= portData_reg[`EXB_P9_LSB+1:`EXB_P9_LSB];
				port9Oe_n[1:0] <= ~portDir_reg[`EXB_P9_LSB+1:`EXB_P9_LSB];
			end
			// Tag strobe follows the address strobe; tag mode is a level
			if (tagMode) begin
				port9Out[2]  <= addrStrobe;                         // R6
				port9Out[3]  <= 1'b1;                               // R6
				port9Oe_n[3:2] <= 2'b00;                            // R6
			end else begin
				// Mixed extended/fetch settings land here as plain mode
				port9Out[3:2]  <= portData_reg[`EXB_P9_MSB:`EXB_P9_MSB-1]; // R5
				port9Oe_n[3:2] <= ~portDir_reg[`EXB_P9_MSB:`EXB_P9_MSB-1]; // R5
			end
		end
	end

endmodule // exb_top

`default_nettype wire

// ==== dv/exb_assertions.sv ====
// Checker for the external bus expansion block, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module exb_assertions (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        reset_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins
	input wire logic [7:0]  port4Oe_n,
	input wire logic [7:0]  port5Oe_n,
	input wire logic [3:0]  port9Out,
	input wire logic [3:0]  port9Oe_n,
	input wire logic        addressLatchStrobe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////////////
	// Access steps: latch strobe, two address cycles, then a strobe
	sequence seqLatch;
		addressLatchStrobe;
	endsequence
	sequence seqRead;
		##2 (port9Out[0] == 1'b0);
	endsequence

	// Reset checks must run while reset is low, so no disable here
	rst_hiz_a: assert property (@(posedge clk_sys) disable iff (1'b0) !reset_n |=>
		(port4Oe_n == 8'hff && port5Oe_n == 8'hff && port9Oe_n == 4'hf))
		else $error("pins driven during reset");
	rst_regs_a: assert property (@(posedge clk_sys) disable iff (1'b0) !reset_n |=>
		(!pready && !pslverr && prdata == 32'h0 && !addressLatchStrobe))
		else $error("outputs not cleared by reset");
	ready_delay_a: assert property (psel && !penable |-> ##[1:2] pready)
		else $error("no answer in time");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than a cycle");
	err_ready_a: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside answer");
	latch_pulse_a: assert property ($rose(addressLatchStrobe) |=> !addressLatchStrobe)
		else $error("latch strobe too long");
	addr_hold_a: assert property (seqLatch |-> port4Oe_n == 8'h00 ##1 port4Oe_n == 8'h00)
		else $error("address not held two cycles");
	strobe_order_a: assert property (seqLatch |-> ##2 (!port9Out[0] || !port9Out[1]))
		else $error("no data strobe after address");
	rd_release_a: assert property (seqLatch ##0 seqRead |-> port4Oe_n == 8'hff)
		else $error("bus driven during read");
endmodule // exb_assertions

bind exb_top exb_assertions chk_u (.clk_sys, .reset_n, .psel, .penable, .prdata, .pready,
	.pslverr, .port4Oe_n, .port5Oe_n, .port9Out, .port9Oe_n, .addressLatchStrobe);

`default_nettype wire

// ==== dv/exb_ext_mem.sv ====
// External memory model on the multiplexed address/data bus
`timescale 1ns/1ps
`default_nettype none

module exb_ext_mem (
	// Clock
	input wire logic        clk_sys,
	// Pins from the device
	input wire logic [7:0]  port4Out,
	input wire logic [7:0]  port4Oe_n,
	input wire logic [7:0]  port5Out,
	input wire logic [7:0]  port5Oe_n,
	input wire logic [3:0]  port9Out,
	input wire logic [3:0]  port9Oe_n,
	input wire logic        addressLatchStrobe,
	// Resolved port 4 level
	output logic [7:0]      port4In
);
	logic [7:0]  mem [0:255];
	logic [15:0] latAddr = 16'h0;
	logic [7:0]  lat5Oe = 8'h0;
	logic        tagSeen = 1'b0;
	logic [7:0]  lastIn = 8'h0;
	int          nStrobe = 0;
	wire         rdLow = !port9Oe_n[0] && !port9Out[0];
	wire         wrLow = !port9Oe_n[1] && !port9Out[1];

	////////////////////////////////////////////////////////////////////////////////
	// Data driven only while the read strobe pin is low
	always_comb begin
		if (rdLow)
			port4In = mem[latAddr[7:0]];
		else if (port4Oe_n != 8'hff)
			port4In = port4Out;
		else
			port4In = ~lastIn;
	end

	// Latch address at the strobe, store data under the write strobe
	always @(posedge clk_sys) begin
		lastIn <= port4In;
		if (addressLatchStrobe) begin
			latAddr <= {port5Out, port4Out};
			lat5Oe <= port5Oe_n;
			tagSeen <= !port9Oe_n[2] && port9Out[2];
			nStrobe <= nStrobe + 1;
		end
		if (wrLow)
			mem[latAddr[7:0]] <= port4Out;
	end
endmodule // exb_ext_mem

`default_nettype wire

// ==== dv/testbench.sv ====
// Register-level testbench for the external bus expansion block
`timescale 1ns/1ps
`default_nettype none
`include "exb_defines.vh"

module testbench;
	logic        clk_sys, reset_n, psel, penable, pwrite, extSel, err;
	logic [7:0]  paddr, port5In;
	logic [31:0] pwdata, rd;
	logic [3:0]  port9In;
	logic [15:0] m;
	wire  [31:0] prdata;
	wire         pready, pslverr, addressLatchStrobe;
	wire  [7:0]  port4In, port4Out, port4Oe_n, port5Out, port5Oe_n;
	wire  [3:0]  port9Out, port9Oe_n;
	int          bad_count = 0, n_tests = 0, cycles = 0, s;
	// Offsets whose reset value is zero
	logic [7:0] s_list [6] = '{`EXB_OFF_MODE, `EXB_OFF_FETCH, `EXB_OFF_WAIT,
		`EXB_OFF_PDATA, `EXB_OFF_PDIR, `EXB_OFF_ACCADR};

	exb_top dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .externalAccessSelect(extSel), .port4In(port4In),
		.port4Out(port4Out), .port4Oe_n(port4Oe_n), .port5In(port5In), .port5Out(port5Out),
		.port5Oe_n(port5Oe_n), .port9In(port9In), .port9Out(port9Out),
		.port9Oe_n(port9Oe_n), .addressLatchStrobe(addressLatchStrobe));
	exb_ext_mem mem_u (.clk_sys(clk_sys), .port4Out(port4Out), .port4Oe_n(port4Oe_n),
		.port5Out(port5Out), .port5Oe_n(port5Oe_n), .port9Out(port9Out),
		.port9Oe_n(port9Oe_n), .addressLatchStrobe(addressLatchStrobe), .port4In(port4In));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard; the ceiling is far above the expected run
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			final_report();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// External access by command, polled until not busy, then status left in rd
	task automatic ext(input logic wr, input logic [15:0] a, input logic [7:0] d);
		apb(1'b1, `EXB_OFF_ACCADR, {16'h0, a});
		apb(1'b1, `EXB_OFF_ACCDAT, {24'h0, d});
		apb(1'b1, `EXB_OFF_ACCCMD, {30'h0, wr, 1'b1});
		do apb(1'b0, `EXB_OFF_STATUS, 32'h0); while (rd[`EXB_ST_BUSY] !== 1'b0);
		apb(1'b0, `EXB_OFF_STATUS, 32'h0);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{psel, penable, pwrite, extSel, reset_n} = 5'h0;
		{paddr, pwdata, port5In, port9In} = 52'h0;
		repeat (8) @(posedge clk_sys);
		check({port4Oe_n, port5Oe_n, port9Oe_n}, 32'hfffff);
		reset_n <= 1'b1;
		foreach (s_list[i]) begin
			apb(1'b0, s_list[i], 32'h0);
			check(rd, 32'h0);
		end
		apb(1'b1, 8'h40, 32'hffffffff);
		apb(1'b0, 8'h40, 32'h0);
		check(rd, 32'h0);
		check(err, 1'b1);
		$display("test reset and map done");
		// General port in port mode
		apb(1'b1, `EXB_OFF_PDIR, 32'hfffff);
		apb(1'b1, `EXB_OFF_PDATA, 32'h95a3c);
		repeat (2) @(posedge clk_sys);
		check({port9Out, port5Out, port4Out}, 32'h95a3c);
		check({port9Oe_n, port5Oe_n, port4Oe_n}, 32'h0);
		apb(1'b1, `EXB_OFF_PDIR, 32'h0);
		port5In <= 8'h69;
		port9In <= 4'h6;
		apb(1'b0, `EXB_OFF_PIN, 32'h0);
		check(rd & 32'hfff00, 32'h66900);
		$display("test general port done");
		// Port 5 address width for each expansion code
		extSel <= 1'b1;
		apb(1'b1, `EXB_OFF_PDATA, 32'h0);
		for (int i = 0; i < 4; i++) begin
			s = (i == 0) ? 0 : 2 * i + 2;
			m = (16'h1 << s) - 16'h1;
			apb(1'b1, `EXB_OFF_MODE, i + 1);
			ext(1'b1, 16'hf6e1, 8'h20 + i);
			check(mem_u.lat5Oe, 8'(~m[7:0]));
			check(mem_u.latAddr & {m[7:0], 8'hff}, 16'hf6e1 & {m[7:0], 8'hff});
			check(mem_u.mem[8'he1], 8'h20 + i);
		end
		$display("test address width done");
		// Write then read back at two wait settings
		for (int w = 0; w < 4; w += 3) begin
			apb(1'b1, `EXB_OFF_WAIT, w);
			ext(1'b1, 16'h4000 + w, 8'hc5 ^ w);
			ext(1'b0, 16'h4000 + w, 8'h0);
			check(rd[`EXB_ST_RD_MSB:0], {8'hc5 ^ 8'(w), 8'h14});
		end
		// Refused accesses: below the area, then access pin low
		s = mem_u.nStrobe;
		ext(1'b1, 16'h3fff, 8'h77);
		check(rd[`EXB_ST_ERR], 1'b1);
		check(mem_u.nStrobe, s);
		apb(1'b1, `EXB_OFF_STATUS, 32'h6);
		extSel <= 1'b0;
		ext(1'b1, 16'h8000, 8'h77);
		check(rd[`EXB_ST_EXP:0], 5'h2);
		check(mem_u.nStrobe, s);
		extSel <= 1'b1;
		$display("test data transfer done");
		// Tag mode, then plain mode with port 9 upper bits general
		apb(1'b1, `EXB_OFF_FETCH, 32'h05);
		apb(1'b1, `EXB_OFF_MODE, 32'h84);
		ext(1'b1, 16'h5000, 8'h3e);
		check({rd[`EXB_ST_TAG], mem_u.tagSeen, port9Out[3]}, 3'h7);
		apb(1'b1, `EXB_OFF_FETCH, 32'h00);
		apb(1'b1, `EXB_OFF_PDIR, 32'hc0000);
		apb(1'b1, `EXB_OFF_PDATA, 32'h40000);
		apb(1'b0, `EXB_OFF_STATUS, 32'h0);
		check({rd[`EXB_ST_TAG], port9Out[3:2], port9Oe_n[3:2]}, 5'h04);
		$display("test mode select done");
		// Reset in mid-run
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check({port4Oe_n, port5Oe_n, port9Oe_n}, 32'hfffff);
		reset_n <= 1'b1;
		apb(1'b0, `EXB_OFF_MODE, 32'h0);
		check(rd, 32'h0);
		$display("test second reset done");
		final_report();
	end
endmodule // testbench

`default_nettype wire
